/* File: common/slow_clock_pkg.sv */
// Summary of operation
// [R1] Divider must be undivided when error correction on
// [R2] Data rate limited by divider code
// [R3] Select fast crystal before radio use
// [R4] Calibrated RC runs at crystal over 750/1500
// [R5] Calibrate only with RC running, crystal stable
// [R6] Only the selected slow oscillator runs
// [R7] Reset enables RC, slow select is 1
// [R8] Change slow select only on fast RC
// [R9] Crystal select starts calibration, repeats continuously
// [R10] One calibration pass lasts about 2 ms
// [R11] Later calibrations abort on switch or sleep
// [R12] Requests during initial calibration wait for it
// [R13] Later requests take effect after 130 us
// [R14] No repeated request within guard interval
// [R15] Slow select returns to 1 after modes 2/3
// [R16] Slow select 0 crystal, 1 RC oscillator
// [R17] Switch system clock only to stable source; wake from modes 2/3 selects fast RC without checking fast_rc_stable
package slow_clock_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] idx_clock_source_control = 10'h0c6;
  localparam logic [9:0] idx_clock_status = 10'h0c7;
  localparam logic [9:0] idx_power_request = 10'h0c8;
  localparam int addr_width = 12;
  // Control register fields
  localparam int slow_sel_bit = 7;
  localparam int sys_sel_bit = 6;
  localparam int tick_lsb = 3;
  localparam int div_lsb = 0;
  localparam logic [2:0] divider_undivided = 3'h0;
  localparam logic rst_slow_sel = 1'h1;
  localparam logic rst_sys_sel = 1'h1;
  localparam logic [2:0] rst_tick = 3'h1;
  localparam logic [2:0] rst_divider = 3'h1;
  // Status register fields
  localparam int st_sys_bit = 0;
  localparam int st_cal_bit = 1;
  localparam int st_init_bit = 2;
  localparam int st_sleep_bit = 3;
  localparam int st_trim_lsb = 8;
  // Power modes
  localparam logic [1:0] pm_active = 2'h0;
  localparam logic [1:0] pm_deep_a = 2'h2;
  // RC trim
  localparam logic [7:0] rst_trim = 8'h80;
  localparam int rc_ratio_narrow = 750;
  localparam int rc_ratio_wide = 1500;
  // Timing
  localparam longint clk_hz = 40000000;
  localparam int cal_time_ms = 2;
  localparam int abort_time_us = 130;
  localparam int cal_cycles = int'(cal_time_ms * clk_hz / 1000);
  localparam int abort_cycles = int'(abort_time_us * clk_hz / 1000000);
  // Clock control sequencer states
  typedef enum logic [7:0] {
    st_rc        = 8'h01,
    st_wait_xosc = 8'h02,
    st_init_cal  = 8'h04,
    st_cont_cal  = 8'h08,
    st_xosc      = 8'h10,
    st_abort     = 8'h20,
    st_wait_rc   = 8'h40,
    st_sleep     = 8'h80
  } clk_state_t;
endpackage

/* File: src/slow_clock_select_and_calibration.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module slow_clock_select_and_calibration
  import slow_clock_pkg::*;
#(
  parameter int cal_len = cal_cycles,
  parameter int abort_len = abort_cycles,
  parameter int rc_ratio = rc_ratio_narrow
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator status and timing ticks
  input wire logic fast_crystal_stable,
  input wire logic fast_rc_stable,
  input wire logic crystal_tick,
  input wire logic rc_edge,
  input wire logic wake,
  // Oscillator control
  output logic sys_clk_sel,
  output logic slow_crystal_enable,
  output logic slow_rc_enable,
  output logic rc_cal_active,
  output logic [7:0] rc_trim,
  output logic [2:0] system_clock_divider,
  output logic [2:0] tick_divider,
  output logic sleep_active,
  output logic [1:0] sleep_mode
);

  clk_state_t state;
  logic osc_req;
  logic slow_clock_select;
  logic pm_pend;
  logic [1:0] pm_req_mode;
  logic init_done;
  logic [31:0] cal_cnt;
  logic [31:0] guard_cnt;
  logic [11:0] period_cnt;
  logic access;
  logic wr_en;
  logic [9:0] idx;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_pwr;
  logic cal_run;
  logic cal_done;
  logic guard_done;

  // APB decode, one wait state per access
  assign access = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;
  assign idx = paddr[addr_width-1:2];
  assign hit_ctrl = (idx == idx_clock_source_control);
  assign hit_stat = (idx == idx_clock_status);
  assign hit_pwr = (idx == idx_power_request);
  // Calibration only with RC running and crystal stable
  // [R5] calibration gating
  assign cal_run = ((state == st_init_cal) | (state == st_cont_cal)) & slow_rc_enable
                   & fast_crystal_stable;
  // [R10] pass length
  assign cal_done = cal_run & (cal_cnt == 32'(cal_len - 1));
  assign guard_done = (guard_cnt == 32'(abort_len - 1));

  // Ready, read data and error response
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= access;
      pslverr <= access & ~(hit_ctrl | hit_stat | hit_pwr);
      prdata <= 32'h0;
      if (access & ~pwrite)
      begin
        if (hit_ctrl)
        begin
          prdata[slow_sel_bit] <= slow_clock_select;
          prdata[sys_sel_bit] <= sys_clk_sel;
          prdata[tick_lsb +: 3] <= tick_divider;
          prdata[div_lsb +: 3] <= system_clock_divider;
        end
        else if (hit_stat)
        begin
          prdata[st_sys_bit] <= sys_clk_sel;
          prdata[st_cal_bit] <= rc_cal_active;
          prdata[st_init_bit] <= init_done;
          prdata[st_sleep_bit] <= sleep_active;
          prdata[st_trim_lsb +: 8] <= rc_trim;
        end
        else if (hit_pwr)
        begin
          prdata[1:0] <= pm_req_mode;
          prdata[2] <= pm_pend;
        end
      end
    end
  end

  // Clock control register fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // [R7] reset selects RC
      slow_clock_select <= rst_slow_sel;
      osc_req <= rst_sys_sel;
      tick_divider <= rst_tick;
      system_clock_divider <= rst_divider;
    end
    else if (state == st_sleep && wake && sleep_mode >= pm_deep_a)
    begin
      // [R15] not retained in deep sleep
      slow_clock_select <= rst_slow_sel;
    end
    else if (wr_en && hit_ctrl)
    begin
      osc_req <= pwdata[sys_sel_bit];
      tick_divider <= pwdata[tick_lsb +: 3];
      system_clock_divider <= pwdata[div_lsb +: 3];
      // [R8] slow select only on fast RC
      if (sys_clk_sel && state == st_rc)
        slow_clock_select <= pwdata[slow_sel_bit];
    end
  end

  // Power mode request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pm_pend <= 1'b0;
      pm_req_mode <= pm_active;
    end
    else if (wr_en && hit_pwr && pwdata[1:0] != pm_active)
    begin
      // [R14] a repeat while pending is absorbed
      pm_pend <= 1'b1;
      pm_req_mode <= pwdata[1:0];
    end
    else if (state == st_sleep)
      pm_pend <= 1'b0;
  end

  // Clock source sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= st_rc;
      sys_clk_sel <= rst_sys_sel;
      init_done <= 1'b0;
    end
    else
    begin
      case (state)
        st_rc:
          if (pm_pend)
            state <= st_sleep;
          else if (!osc_req)
            state <= st_wait_xosc;
        st_wait_xosc:
          // [R17] wait for stable crystal
          if (fast_crystal_stable)
          begin
            sys_clk_sel <= 1'b0;
            init_done <= 1'b0;
            // [R9] start calibration only when slow RC is selected
            state <= slow_clock_select ? st_init_cal : st_xosc;
          end
        st_init_cal:
          // [R12] requests deferred to end of pass
          if (cal_done)
          begin
            init_done <= 1'b1;
            if (pm_pend)
              state <= st_sleep;
            else if (osc_req)
              state <= st_wait_rc;
            else
              state <= st_cont_cal;
          end
        st_cont_cal:
          // [R11] abort on switch or sleep
          if (pm_pend || osc_req)
            state <= st_abort;
        st_xosc:
          if (pm_pend)
            state <= st_sleep;
          else if (osc_req)
            state <= st_wait_rc;
        st_abort:
          // [R13] guard before carrying out request
          if (guard_done)
          begin
            if (pm_pend)
              state <= st_sleep;
            else if (osc_req)
              state <= st_wait_rc;
            else
              state <= st_cont_cal;
          end
        st_wait_rc:
          // [R17] wait for stable fast RC
          if (fast_rc_stable)
          begin
            sys_clk_sel <= 1'b1;
            state <= st_rc;
          end
        st_sleep:
          if (wake)
          begin
            if (sleep_mode >= pm_deep_a)
              sys_clk_sel <= 1'b1;
            state <= st_rc;
          end
        default:
          state <= st_rc;
      endcase
    end
  end

  // Sleep outputs follow the sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_active <= 1'b0;
      sleep_mode <= pm_active;
    end
    else if (state != st_sleep && pm_pend && (state == st_rc || state == st_xosc
             || (state == st_init_cal && cal_done) || (state == st_abort && guard_done)))
    begin
      sleep_active <= 1'b1;
      sleep_mode <= pm_req_mode;
    end
    else if (state == st_sleep && wake)
    begin
      sleep_active <= 1'b0;
      sleep_mode <= pm_active;
    end
  end

  // Calibration pass and abort guard timers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cal_cnt <= 32'h0;
      guard_cnt <= 32'h0;
    end
    else
    begin
      // [R9] passes repeat while crystal and slow RC selected
      if (!cal_run || cal_done)
        cal_cnt <= 32'h0;
      else
        cal_cnt <= cal_cnt + 32'h1;
      if (state != st_abort || guard_done)
        guard_cnt <= 32'h0;
      else
        guard_cnt <= guard_cnt + 32'h1;
    end
  end

  // RC period measurement against crystal ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      period_cnt <= 12'h0;
      rc_trim <= rst_trim;
      rc_cal_active <= 1'b0;
    end
    else
    begin
      rc_cal_active <= cal_run;
      if (!cal_run || rc_edge)
        period_cnt <= 12'h0;
      else if (crystal_tick)
        period_cnt <= period_cnt + 12'h1;
      // [R4] steer period to crystal over ratio
      if (cal_run && rc_edge)
      begin
        if (period_cnt > 12'(rc_ratio) && rc_trim != 8'hff)
          rc_trim <= rc_trim + 8'h1;
        else if (period_cnt < 12'(rc_ratio) && rc_trim != 8'h00)
          rc_trim <= rc_trim - 8'h1;
      end
    end
  end

  // Slow oscillator enables, never both on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_rc_enable <= 1'b1;
      slow_crystal_enable <= 1'b0;
    end
    else
    begin
      // [R6] exclusive enables
      // [R16] select encoding
      slow_rc_enable <= slow_clock_select;
      slow_crystal_enable <= ~slow_clock_select;
    end
  end

endmodule

/* File: testbench/slow_clock_properties.sv */
`timescale 1ns/1ps
module slow_clock_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fast_crystal_stable,
  input wire logic fast_rc_stable,
  input wire logic sys_clk_sel,
  input wire logic slow_crystal_enable,
  input wire logic slow_rc_enable,
  input wire logic rc_cal_active,
  input wire logic [7:0] rc_trim,
  input wire logic sleep_active,
  input wire logic [1:0] sleep_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_excl; !(slow_crystal_enable && slow_rc_enable); endproperty
  a_excl: assert property (p_excl)
    else $error("both slow oscillators enabled");
  property p_boot; $rose(presetn) |-> sys_clk_sel && slow_rc_enable && rc_trim == 8'h80;
  endproperty
  a_boot: assert property (p_boot)
    else $error("wrong state after reset");
  property p_xstable; $fell(sys_clk_sel) |-> $past(fast_crystal_stable); endproperty
  a_xstable: assert property (p_xstable)
    else $error("moved to crystal before it was stable");
  property p_rstable; $rose(sys_clk_sel) && !$past(sleep_active) |-> $past(fast_rc_stable);
  endproperty
  a_rstable: assert property (p_rstable)
    else $error("moved to fast RC before it was stable");
  property p_calrc; rc_cal_active |-> slow_rc_enable; endproperty
  a_calrc: assert property (p_calrc)
    else $error("calibrating a stopped oscillator");
  property p_calstart; $rose(rc_cal_active) |-> !sys_clk_sel; endproperty
  a_calstart: assert property (p_calstart)
    else $error("calibration started off the crystal");
  property p_calrun; $rose(rc_cal_active) |-> rc_cal_active [*8]; endproperty
  a_calrun: assert property (p_calrun)
    else $error("calibration pass too short");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready longer than one cycle");
  property p_sleep; sleep_active |-> sleep_mode != 2'h0; endproperty
  a_sleep: assert property (p_sleep)
    else $error("asleep without a mode");
endmodule
bind slow_clock_select_and_calibration slow_clock_checker u_chk (.pclk(pclk),
  .presetn(presetn), .pready(pready), .pslverr(pslverr),
  .fast_crystal_stable(fast_crystal_stable), .fast_rc_stable(fast_rc_stable),
  .sys_clk_sel(sys_clk_sel),
  .slow_crystal_enable(slow_crystal_enable), .slow_rc_enable(slow_rc_enable),
  .rc_cal_active(rc_cal_active), .rc_trim(rc_trim), .sleep_active(sleep_active),
  .sleep_mode(sleep_mode));

/* File: testbench/test_slow_clock_select_and_calibration.sv */
`timescale 1ns/1ps
module test_slow_clock_select_and_calibration;
  import slow_clock_pkg::*;
  localparam logic [11:0] ctl = {idx_clock_source_control, 2'h0};
  localparam logic [11:0] sts = {idx_clock_status, 2'h0};
  localparam logic [11:0] pwr = {idx_power_request, 2'h0};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, xstab = 0, rstab = 1, redge = 0, wake = 0;
  logic sys_clk_sel, slow_crystal_enable, slow_rc_enable, rc_cal_active, sleep_active;
  logic [7:0] rc_trim;
  logic [1:0] sleep_mode;
  logic [2:0] rcnt = 3'h0;
  int fail_count = 0, num_checks = 0, n;

  // Bus clock
  always #12.5 pclk = ~pclk;
  // Slow RC edge once every eight cycles
  always @(posedge pclk)
  begin
    rcnt <= rcnt + 3'h1;
    redge <= (rcnt == 3'h7);
  end

  slow_clock_select_and_calibration #(.cal_len(50), .abort_len(20), .rc_ratio(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_crystal_stable(xstab), .fast_rc_stable(rstab), .crystal_tick(1'b1),
    .rc_edge(redge), .wake(wake), .sys_clk_sel(sys_clk_sel),
    .slow_crystal_enable(slow_crystal_enable), .slow_rc_enable(slow_rc_enable),
    .rc_cal_active(rc_cal_active), .rc_trim(rc_trim), .system_clock_divider(),
    .tick_divider(), .sleep_active(sleep_active), .sleep_mode(sleep_mode));

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // One APB transfer; result left in r and e
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k == 20)
    begin
      chk(32'h0, 32'h1);
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Count cycles until the system clock select reaches v
  task automatic wait_sel(input logic v);
    n = 0;
    while (sys_clk_sel !== v && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 200)
    begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ctl, 32'h0);
    chk(r, 32'hc9);
    chk({30'h0, slow_rc_enable, slow_crystal_enable}, 32'h2);
    apb(1'b0, 12'h0, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    apb(1'b1, ctl, 32'h49);
    repeat (2) @(posedge pclk);
    chk({30'h0, slow_rc_enable, slow_crystal_enable}, 32'h1);
    apb(1'b1, ctl, 32'hc9);
    repeat (2) @(posedge pclk);
    chk({30'h0, slow_rc_enable, slow_crystal_enable}, 32'h2);
    $display("test slow select done");
    apb(1'b1, ctl, 32'h89);
    repeat (5) @(posedge pclk);
    chk({31'h0, sys_clk_sel}, 32'h1);
    xstab <= 1'b1;
    wait_sel(1'b0);
    apb(1'b1, ctl, 32'hc9);
    repeat (10) @(posedge pclk);
    chk({30'h0, sys_clk_sel, rc_cal_active}, 32'h1);
    wait_sel(1'b1);
    chk({31'h0, n > 30}, 32'h1);
    chk({31'h0, rc_trim > 8'h80}, 32'h1);
    $display("test initial calibration done");
    apb(1'b1, ctl, 32'h88);
    wait_sel(1'b0);
    repeat (60) @(posedge pclk);
    apb(1'b0, ctl, 32'h0);
    chk(r, 32'h88);
    apb(1'b0, sts, 32'h0);
    chk(r & 32'h7, 32'h6);
    apb(1'b1, ctl, 32'h49);
    wait_sel(1'b1);
    chk({31'h0, n >= 18 && n <= 30}, 32'h1);
    apb(1'b0, ctl, 32'h0);
    chk(r, 32'hc9);
    $display("test abort done");
    apb(1'b1, ctl, 32'h49);
    apb(1'b1, ctl, 32'h09);
    wait_sel(1'b0);
    rstab <= 1'b0;
    repeat (10) @(posedge pclk);
    chk({31'h0, rc_cal_active}, 32'h0);
    apb(1'b1, ctl, 32'h49);
    repeat (10) @(posedge pclk);
    chk({31'h0, sys_clk_sel}, 32'h0);
    rstab <= 1'b1;
    wait_sel(1'b1);
    $display("test crystal slow source done");
    apb(1'b1, pwr, 32'h2);
    repeat (3) @(posedge pclk);
    chk({29'h0, sleep_active, sleep_mode}, 32'h6);
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, ctl, 32'h0);
    chk({30'h0, r[7:6]}, 32'h3);
    $display("test sleep done");
    summarize();
  end
endmodule
